// >>> cpu_model.sv
// partner model: cpu core issuing data space loads and stores
`timescale 1ns/10ps
module cpu_model
  import dsd_pkg::*;
(
  // clock
  input  wire logic          clk_sys,
  // request toward the decoder
  output dsd_pkg::data_req_t data_req
);
  initial data_req = '0;

  // -----------------------------------------------------------------
  // one byte per access
  // -----------------------------------------------------------------
  // the request drops after the taking edge; a held request would be taken twice
  // released lines show the inverse so stale values never pass
  task automatic access(input logic wr, input logic stk, input logic [15:0] a);
    @(negedge clk_sys);
    data_req = '{valid: 1'b1, write: wr, stack: stk, addr: a, wdata: a[7:0]};
    @(posedge clk_sys);
    @(negedge clk_sys);
    data_req = '{valid: 1'b0, write: ~wr, stack: ~stk, addr: ~a, wdata: ~a[7:0]};
  endtask
endmodule

// >>> data_space_decoder.sv
// data space decoder: map, wait timing, i/o alias and eeprom stalls
`timescale 1ns/10ps
module data_space_decoder
  import dsd_pkg::*;
#(
  parameter int unsigned EE_WRITE_CYCLES = EE_WRITE_CYC
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // configuration
  input  wire logic              legacy_layout_pin,
  input  wire logic              external_sram_enable,
  input  wire logic [1:0]        wait_states,
  input  wire logic              power_down_req,
  // cpu data side
  input  wire dsd_pkg::data_req_t data_req,
  input  wire dsd_pkg::io_req_t   io_req,
  input  wire dsd_pkg::ee_req_t   ee_req,
  input  wire logic [7:0]        io_rdata,
  input  wire logic [PROG_CNT_W-1:0] program_counter,
  output logic                   cpu_stall,
  output logic                   io_illegal,
  output logic                   bit_whole_rewrite,
  output logic [15:0]            pm_word_addr,
  // memory side
  output dsd_pkg::sel_t          sel_q,
  output logic                   ext_rd_q,
  output logic                   ext_wr_q,
  output logic [7:0]             ext_wdata_q,
  output logic                   bus_fault_q,
  output logic                   ee_busy,
  output logic                   ee_write_pulse,
  output logic [10:0]            ee_addr_q,
  output logic                   osc_keep_on,
  output logic                   legacy_q
);
  import dsd_pkg::*;

  if (EE_WRITE_CYCLES < 1 || EE_WRITE_CYCLES >= 2**24) begin : g_bad_ee
    $error("eeprom write count must be nonzero and fit the 24-bit timer");
  end

  // ------------------------------------------------------------
  // layout latch and program space
  // ------------------------------------------------------------
  logic rst_seen_q;
  always_ff @(posedge clk_sys) begin
    rst_seen_q <= rst;
    if (rst) legacy_q <= legacy_layout_pin;
  end

  // word address of the 32K x 16 program store
  assign pm_word_addr = {1'b0, program_counter};

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire [15:0] a          = data_req.addr;
  wire        in_regf    = a < STDIO_BASE;
  wire        in_stdio   = (a >= STDIO_BASE) && (a < EXTIO_BASE);
  wire        in_extio   = !legacy_q && (a >= EXTIO_BASE) && (a <= EXTIO_TOP);
  wire [15:0] sram_base  = legacy_q ? SRAM_BASE_L : SRAM_BASE_N;
  wire [15:0] ext_base   = legacy_q ? EXT_BASE_L : EXT_BASE_N;
  wire        in_sram    = (a >= sram_base) && (a < ext_base);
  wire        in_ext     = a >= ext_base;
  wire        ext_ok     = in_ext && external_sram_enable;
  wire [15:0] sram_off   = a - sram_base;

  target_t tgt;
  assign tgt = in_regf ? TGT_REGF : in_stdio ? TGT_STDIO : in_extio ? TGT_EXTIO :
               in_sram ? TGT_SRAM : TGT_EXT;

  // ------------------------------------------------------------
  // access timing
  // ------------------------------------------------------------
  // extra cycles per byte: 1 at zero wait, else wait_states+1
  wire [3:0] byte_xtra = (wait_states == 2'd0) ? EXT_XTRA_0WS
                       : 4'({2'b00, wait_states} + 4'd1);
  // stack pushes two pc bytes: 3,5,7,9
  wire [3:0] stk_xtra  = (wait_states == 2'd0) ? STK_XTRA_0WS
                       : 4'({1'b0, wait_states, 1'b0} + 4'd3);
  wire [3:0] xtra      = data_req.stack ? stk_xtra : byte_xtra;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_INT  = 4'b0010,
    ST_EXT  = 4'b0100,
    ST_EE   = 4'b1000
  } state_t;

  state_t    state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  wire start_int = data_req.valid && !in_ext;
  wire start_ext = data_req.valid && ext_ok;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (ee_req.valid) begin
          state_d = ST_EE;
          cnt_d   = ee_req.write ? EE_WR_STALL - 4'd1 : EE_RD_STALL - 4'd1;
        end else if (start_ext) begin
          state_d = ST_EXT;
          cnt_d   = xtra - 4'd1;
        end else if (start_int) begin
          state_d = ST_INT;
          cnt_d   = 4'({2'b00, SRAM_CYCLES} - 4'd2);
        end
      end
      ST_INT: state_d = ST_IDLE; // second cycle of two
      ST_EXT, ST_EE: begin
        if (cnt_q == 4'd0) state_d = ST_IDLE;
        else cnt_d = cnt_q - 4'd1;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'd0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign cpu_stall = (state_q == ST_EXT) || (state_q == ST_EE) ||
                     (state_q == ST_IDLE && (ee_req.valid || start_ext));

  // ------------------------------------------------------------
  // memory selects and external strobes
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_q       <= '0;
      ext_rd_q    <= 1'b0;
      ext_wr_q    <= 1'b0;
      ext_wdata_q <= 8'h00;
      bus_fault_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && data_req.valid && !ee_req.valid) begin
        sel_q.sel_regf   <= (tgt == TGT_REGF);
        sel_q.sel_io     <= (tgt == TGT_STDIO) || (tgt == TGT_EXTIO);
        sel_q.sel_sram   <= (tgt == TGT_SRAM);
        sel_q.sel_ext    <= ext_ok;
        sel_q.local_addr <= in_sram ? sram_off : a;
        ext_rd_q         <= ext_ok && !data_req.write;
        ext_wr_q         <= ext_ok && data_req.write;
        ext_wdata_q      <= data_req.wdata;
        bus_fault_q      <= in_ext && !external_sram_enable;
      end else if (state_d == ST_IDLE) begin
        sel_q    <= '0;
        ext_rd_q <= 1'b0;
        ext_wr_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // io port instructions
  // ------------------------------------------------------------
  // port numbers only cover 0x00-0x3F; data space sees them 0x20 higher
  wire [15:0] io_data_addr = {10'd0, io_req.addr} + {10'd0, IO_ALIAS};
  assign io_illegal        = io_req.valid && io_req.bit_op &&
                             (io_req.addr > BIT_IO_TOP);
  // read-modify-write of all bits: flags read as one get cleared too
  assign bit_whole_rewrite = io_req.valid && io_req.bit_op && !io_illegal &&
                             io_req.write && (io_data_addr < EXTIO_BASE);

  // ------------------------------------------------------------
  // eeprom write timer
  // ------------------------------------------------------------
  // no reset on the timer: a write under way must finish across reset
  logic [23:0] ee_tmr_q;
  logic        ee_tmr_live_q;
  wire ee_wr_go = ee_req.valid && ee_req.write && state_q == ST_IDLE && !ee_busy;
  always_ff @(posedge clk_sys) begin
    if (ee_wr_go) begin
      ee_tmr_q      <= 24'(EE_WRITE_CYCLES);
      ee_tmr_live_q <= 1'b1;
      ee_addr_q     <= ee_req.addr;
    end else if (ee_tmr_live_q && ee_tmr_q != 24'd0) begin
      ee_tmr_q <= ee_tmr_q - 24'd1;
    end else begin
      ee_tmr_q      <= 24'd0;
      ee_tmr_live_q <= 1'b0;
    end
  end
  assign ee_write_pulse = ee_wr_go;
  assign ee_busy        = ee_tmr_live_q === 1'b1;
  assign osc_keep_on    = ee_busy && power_down_req;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_strobe_internal: assert property (@(posedge clk_sys) disable iff (rst)
    sel_q.sel_sram |-> !ext_rd_q && !ext_wr_q)
    else $error("external strobe during internal access");
  a_no_alias: assert property (@(posedge clk_sys) disable iff (rst)
    bus_fault_q |-> !sel_q.sel_sram && !sel_q.sel_ext)
    else $error("disabled external access reached memory");
  a_ee_read_stall: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_IDLE && ee_req.valid && !ee_req.write)
      |=> (state_q == ST_EE)[*4] ##1 state_q == ST_IDLE)
    else $error("eeprom read stall not four cycles");
  a_ee_write_stall: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_IDLE && ee_req.valid && ee_req.write)
      |=> (state_q == ST_EE)[*2] ##1 state_q == ST_IDLE)
    else $error("eeprom write stall not two cycles");
  a_int_two_cyc: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_INT) |=> state_q == ST_IDLE)
    else $error("internal access over two cycles");
  a_ext_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_IDLE && data_req.valid && !ee_req.valid && in_ext && !external_sram_enable)
      |=> !ext_rd_q && !ext_wr_q)
    else $error("external strobe while disabled");
  a_ext_zero_ws: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_IDLE && start_ext && !ee_req.valid && !data_req.stack && wait_states == 2'd0)
      |=> state_q == ST_EXT ##1 state_q == ST_IDLE)
    else $error("zero wait external access not one extra cycle");
  a_stack_three_ws: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_IDLE && start_ext && !ee_req.valid && data_req.stack && wait_states == 2'd3)
      |=> (state_q == ST_EXT)[*8] ##1 state_q == ST_EXT ##1 state_q == ST_IDLE)
    else $error("external stack with three waits not nine cycles");
  a_legacy_held: assert property (@(posedge clk_sys) disable iff (rst || rst_seen_q)
    $stable(legacy_q))
    else $error("layout changed at run time");
  a_bit_range: assert property (@(posedge clk_sys) disable iff (rst)
    (io_req.valid && io_req.bit_op && io_req.addr == 6'h20) |-> io_illegal)
    else $error("bit access above 0x1F accepted");

  // ------------------------------------------------------------
  // decode checks
  // ------------------------------------------------------------
  // request taken: idle, data request up, no eeprom request ahead of it
  wire taken = state_q == ST_IDLE && data_req.valid && !ee_req.valid;
  a_regf_select: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && a < STDIO_BASE) |=> sel_q.sel_regf)
    else $error("register file address not selected");
  a_extio_select: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && !legacy_q && a >= EXTIO_BASE && a <= EXTIO_TOP) |=> sel_q.sel_io)
    else $error("extended io address not selected");
  a_legacy_sram: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && legacy_q && a >= EXTIO_BASE && a <= EXTIO_TOP)
      |=> sel_q.sel_sram && !sel_q.sel_io)
    else $error("legacy layout kept extended io");
  a_ext_route: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && in_ext && external_sram_enable) |=> sel_q.sel_ext)
    else $error("external address not routed out");
  a_one_strobe: assert property (@(posedge clk_sys) disable iff (rst)
    !(ext_rd_q && ext_wr_q))
    else $error("read and write strobes together");
  a_strobe_ext_only: assert property (@(posedge clk_sys) disable iff (rst)
    (ext_rd_q || ext_wr_q) |-> sel_q.sel_ext)
    else $error("strobe without external select");
  a_pm_range: assert property (@(posedge clk_sys) disable iff (rst)
    pm_word_addr < 16'(PM_WORDS))
    else $error("program word address outside store");

  // ------------------------------------------------------------
  // timing checks
  // ------------------------------------------------------------
  // wait rows not covered above: one and three waits, zero-wait stack
  a_ext_one_ws: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && start_ext && !data_req.stack && wait_states == 2'd1)
      |=> (state_q == ST_EXT)[*2] ##1 state_q == ST_IDLE)
    else $error("one wait external access not two extra cycles");
  a_ext_three_ws: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && start_ext && !data_req.stack && wait_states == 2'd3)
      |=> (state_q == ST_EXT)[*4] ##1 state_q == ST_IDLE)
    else $error("three wait external access not four extra cycles");
  a_stack_zero_ws: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && start_ext && data_req.stack && wait_states == 2'd0)
      |=> (state_q == ST_EXT)[*3] ##1 state_q == ST_IDLE)
    else $error("zero wait external stack not three extra cycles");
  a_int_no_stall: assert property (@(posedge clk_sys) disable iff (rst)
    (taken && start_int) |-> !cpu_stall)
    else $error("internal access stalled the cpu");

  // ------------------------------------------------------------
  // io and eeprom checks
  // ------------------------------------------------------------
  a_io_no_extio: assert property (@(posedge clk_sys) disable iff (rst)
    io_req.valid |-> io_data_addr < EXTIO_BASE)
    else $error("io port instruction reached extended io");
  a_io_alias: assert property (@(posedge clk_sys) disable iff (rst)
    io_req.valid |-> io_data_addr >= STDIO_BASE)
    else $error("io port not shifted into data space");
  a_bit_rewrite: assert property (@(posedge clk_sys) disable iff (rst)
    (io_req.valid && io_req.bit_op && io_req.write && io_req.addr <= BIT_IO_TOP)
      |-> bit_whole_rewrite)
    else $error("legal bit write did not rewrite register");
  a_ee_addr: assert property (@(posedge clk_sys) disable iff (rst)
    ee_wr_go |=> ee_addr_q == $past(ee_req.addr))
    else $error("eeprom write address not kept");
  a_ee_busy_start: assert property (@(posedge clk_sys) disable iff (rst)
    ee_wr_go |=> ee_busy)
    else $error("eeprom write started without busy");
  a_osc_keep: assert property (@(posedge clk_sys) disable iff (rst)
    (ee_busy && power_down_req) |-> osc_keep_on)
    else $error("oscillator released during eeprom write");
  // busy length counter, kept through reset like the timer it watches
  logic [24:0] ee_busy_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!ee_busy) ee_busy_cnt_q <= 25'd0;
    else ee_busy_cnt_q <= ee_busy_cnt_q + 25'd1;
  end
  a_ee_busy_len: assert property (@(posedge clk_sys)
    ee_busy |-> ee_busy_cnt_q <= 25'(EE_WRITE_CYCLES))
    else $error("eeprom busy longer than write time");
  a_ee_over_reset: assert property (@(posedge clk_sys)
    (rst && ee_busy && ee_tmr_q != 24'd0) |=> ee_busy)
    else $error("reset cut an eeprom write short");
endmodule

// >>> dsd_pkg.sv
// constants and carrier types for the data space decoder
package dsd_pkg;
  localparam int unsigned PM_WORDS      = 32768;
  localparam int unsigned PROG_CNT_W    = 15;
  localparam logic [15:0] REGF_BASE     = 16'h0000;
  localparam logic [15:0] STDIO_BASE    = 16'h0020;
  localparam logic [15:0] EXTIO_BASE    = 16'h0060;
  localparam logic [15:0] EXTIO_TOP     = 16'h00FF;
  localparam logic [15:0] SRAM_BASE_N   = 16'h0100;
  localparam logic [15:0] SRAM_BASE_L   = 16'h0060;
  localparam logic [15:0] SRAM_SIZE_N   = 16'h1000;
  localparam logic [15:0] SRAM_SIZE_L   = 16'h0FA0;
  localparam logic [15:0] EXT_BASE_N    = 16'h1100;
  localparam logic [15:0] EXT_BASE_L    = 16'h1000;
  localparam logic [5:0]  IO_ALIAS      = 6'h20;
  localparam logic [5:0]  BIT_IO_TOP    = 6'h1F;
  localparam logic [3:0]  EXT_XTRA_0WS  = 4'h1;
  localparam logic [3:0]  STK_XTRA_0WS  = 4'h3;
  localparam logic [3:0]  EE_RD_STALL   = 4'h4;
  localparam logic [3:0]  EE_WR_STALL   = 4'h2;
  localparam logic [1:0]  SRAM_CYCLES   = 2'h2;
  localparam int unsigned EE_BYTES      = 2048;
  localparam int unsigned EE_WRITE_NS   = 8500000;
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned EE_WRITE_CYC  = EE_WRITE_NS / CLK_NS;

  typedef enum logic [4:0] {
    TGT_REGF  = 5'b00001,
    TGT_STDIO = 5'b00010,
    TGT_EXTIO = 5'b00100,
    TGT_SRAM  = 5'b01000,
    TGT_EXT   = 5'b10000
  } target_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        stack;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } data_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        bit_op;
    logic [5:0]  addr;
  } io_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } ee_req_t;

  typedef struct packed {
    logic        sel_regf;
    logic        sel_io;
    logic        sel_sram;
    logic        sel_ext;
    logic [15:0] local_addr;
  } sel_t;
endpackage

// >>> tb.sv
// self-checking testbench for the data space decoder
`timescale 1ns/10ps
module tb;
  import dsd_pkg::*;
  localparam int unsigned EE_CYC = 20;
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  logic            legacy_layout_pin = 1'b0;
  logic            external_sram_enable = 1'b1;
  logic [1:0]      wait_states = 2'h0;
  logic            power_down_req = 1'b0;
  data_req_t       data_req;
  io_req_t         io_req = '0;
  ee_req_t         ee_req = '0;
  logic [PROG_CNT_W-1:0] program_counter = '0;
  logic            cpu_stall, io_illegal, bit_whole_rewrite, bus_fault_q, ee_busy;
  logic            ext_rd_q, ext_wr_q, ee_write_pulse, osc_keep_on, legacy_q;
  logic [15:0]     pm_word_addr;
  logic [7:0]      ext_wdata_q;
  logic [10:0]     ee_addr_q;
  sel_t            sel_q;
  int              error_cnt = 0;
  int              checks_done = 0;

  always #4 clk_sys = ~clk_sys;

  cpu_model cpu_model_inst (.clk_sys(clk_sys), .data_req(data_req));

  data_space_decoder #(.EE_WRITE_CYCLES(EE_CYC)) data_space_decoder_inst (
    .clk_sys(clk_sys), .rst(rst), .legacy_layout_pin(legacy_layout_pin),
    .external_sram_enable(external_sram_enable), .wait_states(wait_states),
    .power_down_req(power_down_req), .data_req(data_req), .io_req(io_req),
    .ee_req(ee_req), .io_rdata(8'hA5), .program_counter(program_counter),
    .cpu_stall(cpu_stall), .io_illegal(io_illegal), .bit_whole_rewrite(bit_whole_rewrite),
    .pm_word_addr(pm_word_addr), .sel_q(sel_q), .ext_rd_q(ext_rd_q), .ext_wr_q(ext_wr_q),
    .ext_wdata_q(ext_wdata_q), .bus_fault_q(bus_fault_q), .ee_busy(ee_busy),
    .ee_write_pulse(ee_write_pulse), .ee_addr_q(ee_addr_q), .osc_keep_on(osc_keep_on),
    .legacy_q(legacy_q));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic lg);
    @(negedge clk_sys);
    rst = 1'b1;
    legacy_layout_pin = lg;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
  endtask

  // fixed window long enough for nine extra cycles
  task automatic run_access(input logic wr, input logic stk, input logic [15:0] a,
                            output int n_ext, output int n_sram, output int n_flt);
    cpu_model_inst.access(wr, stk, a);
    n_ext = 0;
    n_sram = 0;
    n_flt = 0;
    repeat (12) begin
      n_ext += (ext_rd_q === 1'b1 || ext_wr_q === 1'b1);
      n_sram += (sel_q.sel_sram === 1'b1);
      n_flt += (bus_fault_q === 1'b1);
      @(negedge clk_sys);
    end
  endtask

  function automatic logic [3:0] tgt_now();
    return {sel_q.sel_regf, sel_q.sel_io, sel_q.sel_sram, sel_q.sel_ext};
  endfunction

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_map(input logic lg);
    logic [15:0] an [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
                            16'h10FF, 16'h1100};
    logic [3:0]  tn [8] = '{4'h8, 4'h4, 4'h4, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1};
    logic [15:0] al [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
                            16'h0FFF, 16'h1000};
    logic [3:0]  tl [8] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1};
    logic [15:0] av;
    logic [15:0] lb;
    logic [3:0]  tv;
    do_reset(lg);
    lb = lg ? SRAM_BASE_L : SRAM_BASE_N;
    chk("legacy latch", {15'h0, lg}, {15'h0, legacy_q});
    legacy_layout_pin = ~lg;
    for (int i = 0; i < 8; i++) begin
      av = lg ? al[i] : an[i];
      tv = lg ? tl[i] : tn[i];
      cpu_model_inst.access(1'b0, 1'b0, av);
      chk("target", {12'h0, tv}, {12'h0, tgt_now()});
      chk("local addr", (tv == 4'h2) ? av - lb : av, sel_q.local_addr);
      repeat (12) @(negedge clk_sys);
    end
    chk("legacy held", {15'h0, lg}, {15'h0, legacy_q});
    $display("map test done, legacy %0d", lg);
  endtask

  task automatic t_timing;
    int ne, ns, nf;
    for (int w = 0; w < 4; w++) begin
      wait_states = w[1:0];
      run_access(1'b0, 1'b0, 16'h2000, ne, ns, nf);
      chk("ext cycles", 16'(EXT_XTRA_0WS + w), 16'(ne));
      run_access(1'b1, 1'b1, 16'hFFFF, ne, ns, nf);
      chk("stack cycles", 16'(STK_XTRA_0WS + 2 * w), 16'(ne));
      chk("ext wdata", 16'h00FF, {8'h0, ext_wdata_q});
    end
    run_access(1'b1, 1'b0, 16'h0100, ne, ns, nf);
    chk("internal strobes", 16'h0, 16'(ne));
    chk("sram in two", 16'h1, 16'(ns >= 1 && ns <= 2));
    $display("timing test done");
  endtask

  task automatic t_fault;
    int ne, ns, nf;
    external_sram_enable = 1'b0;
    run_access(1'b0, 1'b0, 16'h1200, ne, ns, nf);
    chk("disabled strobes", 16'h0, 16'(ne));
    chk("fault flag", 16'h1, 16'(nf > 0));
    chk("no alias", 16'h0, 16'(ns));
    external_sram_enable = 1'b1;
    $display("fault test done");
  endtask

  task automatic t_io;
    @(negedge clk_sys);
    io_req = '{valid: 1'b1, write: 1'b1, bit_op: 1'b1, addr: 6'h1F};
    program_counter = 15'h7FFF;
    #1;
    chk("bit legal", 16'h0, {15'h0, io_illegal});
    chk("whole rewrite", 16'h1, {15'h0, bit_whole_rewrite});
    chk("word addr", 16'h7FFF, pm_word_addr);
    io_req.addr = 6'h20;
    #1;
    chk("bit illegal", 16'h1, {15'h0, io_illegal});
    io_req = '0;
    $display("io test done");
  endtask

  // request dropped after its taking edge; a held one would be taken again
  task automatic ee_op(input logic wr, output int n, output logic pw);
    @(negedge clk_sys);
    ee_req = '{valid: 1'b1, write: wr, addr: 11'h7FF, wdata: 8'hC3};
    #1;
    pw = ee_write_pulse;
    @(negedge clk_sys);
    ee_req.valid = 1'b0;
    n = 1;
    while (cpu_stall === 1'b1 && n < 16) begin
      n++;
      @(negedge clk_sys);
    end
  endtask

  task automatic t_ee;
    int n;
    logic pw;
    ee_op(1'b0, n, pw);
    chk("ee read stall", 16'(EE_RD_STALL + 1), 16'(n));
    chk("ee read pulse", 16'h0, {15'h0, pw});
    ee_op(1'b1, n, pw);
    chk("ee write stall", 16'(EE_WR_STALL + 1), 16'(n));
    chk("ee write pulse", 16'h1, {15'h0, pw});
    chk("ee addr", 16'h07FF, {5'h0, ee_addr_q});
    power_down_req = 1'b1;
    @(negedge clk_sys);
    chk("osc kept", 16'h1, {15'h0, osc_keep_on});
    do_reset(1'b0);
    chk("busy over reset", 16'h1, {15'h0, ee_busy});
    n = 0;
    while (ee_busy !== 1'b0 && n < EE_CYC + 8) begin
      n++;
      @(negedge clk_sys);
    end
    chk("write ends", 16'h1, 16'(n < EE_CYC + 8));
    power_down_req = 1'b0;
    $display("eeprom test done");
  endtask

  initial begin
    t_map(1'b0);
    t_timing;
    t_fault;
    t_io;
    t_ee;
    t_map(1'b1);
    finish_test;
  end
endmodule
